/* File: rtl/link_regs_pkg.sv */
package link_regs_pkg;
   // host register offsets
   localparam logic [7:0]  ADDR_CHIP_ID       = 8'h00;
   localparam logic [7:0]  ADDR_NODE_ACK      = 8'h04;
   localparam logic [7:0]  ADDR_LINK_CTRL     = 8'h08;
   // identification value is arbitrary, not a real part code
   localparam logic [15:0] CHIP_VERSION       = 16'h0001;
   localparam logic [15:0] CHIP_REVISION      = 16'h0002;
   // widths
   localparam int          BUS_ID_W           = 10;
   localparam int          NODE_ID_W          = 6;
   localparam int          ACK_W              = 4;
   // field positions as vector indices; index 0 is the word lsb
   localparam int          VERSION_LSB        = 16;
   localparam int          REVISION_LSB       = 0;
   localparam int          BUS_ID_LSB         = 22;
   localparam int          NODE_ID_LSB        = 16;
   localparam int          ACK_LSB            = 4;
   localparam int          ID_VALID_BIT       = 31;
   localparam int          SELF_ID_BIT        = 30;
   // masks and reset values
   localparam logic [31:0] NODE_ADDR_MASK     = 32'hffff_0000;
   localparam logic [31:0] ACK_FIELD_MASK     = 32'h0000_00f0;
   localparam logic [31:0] NODE_ACK_RESET     = 32'hffff_0000;
   localparam logic [31:0] LINK_CTRL_RESET    = 32'h0000_0000;
   // special values
   localparam logic [9:0]  BUS_BROADCAST      = 10'h3ff;
   localparam logic [5:0]  NODE_BROADCAST     = 6'h3f;
   localparam logic [3:0]  ACK_TIMEOUT_CODE   = 4'h0;
   localparam logic [3:0]  ACK_SID_GOOD       = 4'h1;
   localparam logic [3:0]  ACK_SID_BAD        = 4'hd;
endpackage

/* File: rtl/node_cfg_if.sv */
`timescale 1ns/1ns
interface node_cfg_if;
   logic [link_regs_pkg::BUS_ID_W-1:0]  bus_identifier;
   logic [link_regs_pkg::NODE_ID_W-1:0] node_identifier;
   logic                                node_id_valid;
   logic                                self_id_receive_enable;
   modport cfg_src (output bus_identifier, output node_identifier,
                    output node_id_valid, output self_id_receive_enable);
   modport cfg_use (input bus_identifier, input node_identifier,
                    input node_id_valid, input self_id_receive_enable);
endinterface

/* File: rtl/packet_accept_filter.sv */
`timescale 1ns/1ns
module packet_accept_filter (
   input  wire logic                                clk_sys,
   input  wire logic                                rst_n,
   node_cfg_if.cfg_use                              cfg,
   input  wire logic                                pkt_hdr_valid,
   input  wire logic [link_regs_pkg::BUS_ID_W-1:0]  pkt_dest_bus,
   input  wire logic [link_regs_pkg::NODE_ID_W-1:0] pkt_dest_node,
   output logic                                     decision_valid_reg,
   output logic                                     accept_reg
);
   import link_regs_pkg::*;
   logic bus_ok;
   logic node_ok;
   logic decision_valid_next;
   logic accept_next;

   always_comb begin
      bus_ok  = (pkt_dest_bus == BUS_BROADCAST) ||
                (pkt_dest_bus == cfg.bus_identifier);
      // own address only counts once software marks it valid
      node_ok = (pkt_dest_node == NODE_BROADCAST) ||
                (cfg.node_id_valid && pkt_dest_node == cfg.node_identifier);
      decision_valid_next = pkt_hdr_valid;
      accept_next         = pkt_hdr_valid ? (bus_ok && node_ok) : accept_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         decision_valid_reg <= 1'b0;
         accept_reg         <= 1'b0;
      end else begin
         decision_valid_reg <= decision_valid_next;
         accept_reg         <= accept_next;
      end
   end
endmodule

/* File: rtl/self_id_checker.sv */
`timescale 1ns/1ns
module self_id_checker (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   node_cfg_if.cfg_use      cfg,
   input  wire logic        sid_quadlet_valid,
   input  wire logic [31:0] sid_quadlet,
   input  wire logic        sid_period_end,
   output logic             grf_write_valid_reg,
   output logic [31:0]      grf_write_data_reg
);
   import link_regs_pkg::*;
   typedef enum logic {WAIT_FIRST, WAIT_SECOND} sid_phase_t;
   sid_phase_t  phase_reg, phase_next;
   logic [31:0] first_reg, first_next;
   logic        bad_reg, bad_next;
   logic        seen_reg, seen_next;
   logic        grf_valid_next;
   logic [31:0] grf_data_next;

   always_comb begin
      phase_next     = phase_reg;
      first_next     = first_reg;
      bad_next       = bad_reg;
      seen_next      = seen_reg;
      grf_valid_next = 1'b0;
      grf_data_next  = grf_write_data_reg;
      if (cfg.self_id_receive_enable && sid_quadlet_valid) begin
         grf_valid_next = 1'b1;
         grf_data_next  = sid_quadlet;
         seen_next      = 1'b1;
         unique case (phase_reg)
            WAIT_FIRST: begin
               first_next = sid_quadlet;
               phase_next = WAIT_SECOND;
            end
            WAIT_SECOND: begin
               if (sid_quadlet != ~first_reg) bad_next = 1'b1;
               phase_next = WAIT_FIRST;
            end
         endcase
      end else if (cfg.self_id_receive_enable && sid_period_end && seen_reg) begin
         // a dangling half pair is reported as bad data
         grf_valid_next = 1'b1;
         grf_data_next  = '0;
         grf_data_next[ACK_LSB +: ACK_W] =
            (bad_reg || phase_reg == WAIT_SECOND) ? ACK_SID_BAD : ACK_SID_GOOD;
         phase_next = WAIT_FIRST;
         bad_next   = 1'b0;
         seen_next  = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phase_reg           <= WAIT_FIRST;
         first_reg           <= '0;
         bad_reg             <= 1'b0;
         seen_reg            <= 1'b0;
         grf_write_valid_reg <= 1'b0;
         grf_write_data_reg  <= '0;
      end else begin
         phase_reg           <= phase_next;
         first_reg           <= first_next;
         bad_reg             <= bad_next;
         seen_reg            <= seen_next;
         grf_write_valid_reg <= grf_valid_next;
         grf_write_data_reg  <= grf_data_next;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_SID_PASS: assert property (
      cfg.self_id_receive_enable && sid_quadlet_valid
      |=> grf_write_valid_reg && grf_write_data_reg == $past(sid_quadlet))
      else $error("self-id quadlet not forwarded");
   AST_SID_STATUS: assert property (
      cfg.self_id_receive_enable && sid_period_end && !sid_quadlet_valid && seen_reg
      |=> grf_write_valid_reg &&
          grf_write_data_reg[ACK_LSB +: ACK_W] ==
          ($past(bad_reg || phase_reg == WAIT_SECOND) ? ACK_SID_BAD : ACK_SID_GOOD))
      else $error("self-id status code wrong");
   AST_SID_PAIR: assert property (
      cfg.self_id_receive_enable && sid_quadlet_valid && phase_reg == WAIT_SECOND &&
      sid_quadlet != ~first_reg |=> bad_reg)
      else $error("mismatched pair not flagged");
   COV_SID_BAD: cover property (
      grf_write_valid_reg && grf_write_data_reg[ACK_LSB +: ACK_W] == ACK_SID_BAD);
endmodule

/* File: rtl/link_node_address_control_regs.sv */
`timescale 1ns/1ns
// Functional notes
// - read-only id: version high, revision low
// - node/ack register at 04h, address fields writable
// - ack field writable only while unlock set
// - 10-bit bus id: source and filter
// - always accept destination bus 3FFh
// - 6-bit node id: source and filter
// - always accept broadcast node 3Fh
// - store last received transmit ack code
// - ack timeout writes zero into ack
// - control register at 08h, read/write, zero reset
// - node id valid enables own-address acceptance
// - self-id enable forwards self-id to receive fifo
// - self-id second quadlet is complement of first
// - self-id status code 1h good, Dh bad
module link_node_address_control_regs (
   input  wire logic                                clk_sys,
   input  wire logic                                rst_n,
   input  wire logic                                host_cs_n,
   input  wire logic [7:0]                          host_addr,
   input  wire logic                                host_wr,
   input  wire logic [31:0]                         host_wdata,
   output logic      [31:0]                         host_rdata_reg,
   input  wire logic                                diag_register_write_unlock,
   input  wire logic                                at_ack_valid,
   input  wire logic [link_regs_pkg::ACK_W-1:0]     at_ack_code,
   input  wire logic                                at_ack_timeout,
   input  wire logic                                pkt_hdr_valid,
   input  wire logic [link_regs_pkg::BUS_ID_W-1:0]  pkt_dest_bus,
   input  wire logic [link_regs_pkg::NODE_ID_W-1:0] pkt_dest_node,
   output logic                                     pkt_decision_valid,
   output logic                                     pkt_accept,
   output logic      [15:0]                         source_address_reg,
   output logic                                     node_id_valid_reg,
   output logic                                     self_id_receive_enable_reg,
   input  wire logic                                sid_quadlet_valid,
   input  wire logic [31:0]                         sid_quadlet,
   input  wire logic                                sid_period_end,
   output logic                                     grf_write_valid,
   output logic      [31:0]                         grf_write_data
);
   import link_regs_pkg::*;

   function automatic logic reg_hit(input logic cs_n, input logic [7:0] addr,
                                    input logic [7:0] offset);
      return !cs_n && addr == offset;
   endfunction

   logic [31:0] node_ack_reg, node_ack_next;
   logic [31:0] link_ctrl_reg, link_ctrl_next;
   logic [31:0] host_rdata_next;
   logic [15:0] source_address_next;
   logic        node_id_valid_next;
   logic        self_id_receive_enable_next;
   logic [31:0] node_wmask;
   logic        wr_node;
   logic        wr_ctrl;

   node_cfg_if cfg ();

   // live register values feed the filter so a write takes effect next cycle
   assign cfg.bus_identifier         = node_ack_reg[BUS_ID_LSB +: BUS_ID_W];
   assign cfg.node_identifier        = node_ack_reg[NODE_ID_LSB +: NODE_ID_W];
   assign cfg.node_id_valid          = link_ctrl_reg[ID_VALID_BIT];
   assign cfg.self_id_receive_enable = link_ctrl_reg[SELF_ID_BIT];

   // register write path
   always_comb begin
      wr_node        = reg_hit(host_cs_n, host_addr, ADDR_NODE_ACK) && host_wr;
      wr_ctrl        = reg_hit(host_cs_n, host_addr, ADDR_LINK_CTRL) && host_wr;
      node_wmask     = NODE_ADDR_MASK;
      if (diag_register_write_unlock) node_wmask = NODE_ADDR_MASK | ACK_FIELD_MASK;
      node_ack_next  = node_ack_reg;
      link_ctrl_next = link_ctrl_reg;
      if (wr_node) begin
         // reserved bits never store, so they read back zero
         node_ack_next = (host_wdata & node_wmask) | (node_ack_reg & ~node_wmask);
      end
      // link events win over a host write in the same cycle
      if (at_ack_valid) begin
         node_ack_next[ACK_LSB +: ACK_W] = at_ack_code;
      end else if (at_ack_timeout) begin
         node_ack_next[ACK_LSB +: ACK_W] = ACK_TIMEOUT_CODE;
      end
      if (wr_ctrl) link_ctrl_next = host_wdata;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         node_ack_reg  <= NODE_ACK_RESET;
         link_ctrl_reg <= LINK_CTRL_RESET;
      end else begin
         node_ack_reg  <= node_ack_next;
         link_ctrl_reg <= link_ctrl_next;
      end
   end

   // read path and status outputs
   always_comb begin
      host_rdata_next = host_rdata_reg;
      if (!host_cs_n && !host_wr) begin
         if (reg_hit(host_cs_n, host_addr, ADDR_CHIP_ID)) begin
            host_rdata_next = {CHIP_VERSION, CHIP_REVISION};
         end else if (reg_hit(host_cs_n, host_addr, ADDR_NODE_ACK)) begin
            host_rdata_next = node_ack_reg;
         end else if (reg_hit(host_cs_n, host_addr, ADDR_LINK_CTRL)) begin
            host_rdata_next = link_ctrl_reg;
         end else begin
            host_rdata_next = '0;
         end
      end
      source_address_next         = {cfg.bus_identifier, cfg.node_identifier};
      node_id_valid_next          = cfg.node_id_valid;
      self_id_receive_enable_next = cfg.self_id_receive_enable;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         host_rdata_reg             <= '0;
         source_address_reg         <= NODE_ACK_RESET[31:16];
         node_id_valid_reg          <= 1'b0;
         self_id_receive_enable_reg <= 1'b0;
      end else begin
         host_rdata_reg             <= host_rdata_next;
         source_address_reg         <= source_address_next;
         node_id_valid_reg          <= node_id_valid_next;
         self_id_receive_enable_reg <= self_id_receive_enable_next;
      end
   end

   packet_accept_filter u_filter (
      .clk_sys            (clk_sys),
      .rst_n              (rst_n),
      .cfg                (cfg.cfg_use),
      .pkt_hdr_valid      (pkt_hdr_valid),
      .pkt_dest_bus       (pkt_dest_bus),
      .pkt_dest_node      (pkt_dest_node),
      .decision_valid_reg (pkt_decision_valid),
      .accept_reg         (pkt_accept)
   );

   self_id_checker u_self_id (
      .clk_sys             (clk_sys),
      .rst_n               (rst_n),
      .cfg                 (cfg.cfg_use),
      .sid_quadlet_valid   (sid_quadlet_valid),
      .sid_quadlet         (sid_quadlet),
      .sid_period_end      (sid_period_end),
      .grf_write_valid_reg (grf_write_valid),
      .grf_write_data_reg  (grf_write_data)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_ID_READ: assert property (
      !host_cs_n && !host_wr && host_addr == ADDR_CHIP_ID
      |=> host_rdata_reg == {CHIP_VERSION, CHIP_REVISION})
      else $error("id register read wrong");

   AST_NODE_WRITE: assert property (
      !host_cs_n && host_wr && host_addr == ADDR_NODE_ACK ##1 host_cs_n
      ##1 !host_cs_n && !host_wr && host_addr == ADDR_NODE_ACK
      |=> host_rdata_reg[31:16] == $past(host_wdata[31:16], 3))
      else $error("node address write not read back");

   AST_ACK_LOCKED: assert property (
      wr_node && !diag_register_write_unlock && !at_ack_valid && !at_ack_timeout
      |=> $stable(node_ack_reg[ACK_LSB +: ACK_W]))
      else $error("ack field changed while locked");

   AST_ACK_UNLOCKED: assert property (
      wr_node && diag_register_write_unlock && !at_ack_valid && !at_ack_timeout
      |=> node_ack_reg[ACK_LSB +: ACK_W] == $past(host_wdata[ACK_LSB +: ACK_W]))
      else $error("ack field not written while unlocked");

   AST_ACK_STORE: assert property (
      at_ack_valid |=> node_ack_reg[ACK_LSB +: ACK_W] == $past(at_ack_code))
      else $error("received ack not stored");

   AST_ACK_TIMEOUT: assert property (
      at_ack_timeout && !at_ack_valid |=> node_ack_reg[ACK_LSB +: ACK_W] == ACK_TIMEOUT_CODE)
      else $error("timeout did not clear ack");

   AST_CTRL_WRITE: assert property (
      wr_ctrl |=> link_ctrl_reg == $past(host_wdata))
      else $error("control write lost");

   AST_RESERVED_ZERO: assert property (
      !host_cs_n && !host_wr && host_addr == ADDR_NODE_ACK
      |=> (host_rdata_reg & ~(NODE_ADDR_MASK | ACK_FIELD_MASK)) == 32'h0000_0000)
      else $error("reserved bits not zero");

   AST_BUS_BROADCAST: assert property (
      pkt_hdr_valid && pkt_dest_bus == BUS_BROADCAST && pkt_dest_node == NODE_BROADCAST
      |=> pkt_decision_valid && pkt_accept)
      else $error("broadcast packet rejected");

   AST_OWN_NODE: assert property (
      pkt_hdr_valid && pkt_dest_bus == cfg.bus_identifier &&
      pkt_dest_node == cfg.node_identifier
      |=> pkt_accept == $past(cfg.node_id_valid || cfg.node_identifier == NODE_BROADCAST))
      else $error("own node acceptance wrong");

   AST_FOREIGN_BUS: assert property (
      pkt_hdr_valid && pkt_dest_bus != BUS_BROADCAST && pkt_dest_bus != cfg.bus_identifier
      |=> !pkt_accept)
      else $error("foreign bus accepted");

   AST_SOURCE_ADDR: assert property (
      wr_node && !host_cs_n ##1 !wr_node [*2]
      |-> source_address_reg == node_ack_reg[31:16])
      else $error("source address stale");

   AST_NODE_READ: assert property (
      !host_cs_n && !host_wr && host_addr == ADDR_NODE_ACK
      |=> host_rdata_reg == $past(node_ack_reg))
      else $error("node register read wrong");

   AST_CTRL_READ: assert property (
      !host_cs_n && !host_wr && host_addr == ADDR_LINK_CTRL
      |=> host_rdata_reg == $past(link_ctrl_reg))
      else $error("control register read wrong");

   AST_UNMAPPED_READ: assert property (
      !host_cs_n && !host_wr && host_addr != ADDR_CHIP_ID &&
      host_addr != ADDR_NODE_ACK && host_addr != ADDR_LINK_CTRL
      |=> host_rdata_reg == 32'h0000_0000)
      else $error("unmapped read not zero");

   AST_RDATA_HOLD: assert property (
      host_cs_n || host_wr
      |=> $stable(host_rdata_reg))
      else $error("read data changed without a read");

   AST_CTRL_HOLD: assert property (
      !wr_ctrl
      |=> $stable(link_ctrl_reg))
      else $error("control register changed without a write");

   AST_ADDR_HOLD: assert property (
      !wr_node
      |=> $stable(node_ack_reg[31:16]))
      else $error("node address changed without a write");

   AST_ACK_HOLD: assert property (
      !at_ack_valid && !at_ack_timeout && !(wr_node && diag_register_write_unlock)
      |=> $stable(node_ack_reg[ACK_LSB +: ACK_W]))
      else $error("ack field changed without a cause");

   AST_RESERVED_STORE: assert property (
      (node_ack_reg & ~(NODE_ADDR_MASK | ACK_FIELD_MASK)) == 32'h0000_0000)
      else $error("reserved bits stored");

   AST_IDV_MIRROR: assert property (
      node_id_valid_reg == $past(link_ctrl_reg[ID_VALID_BIT]))
      else $error("node id valid output stale");

   AST_SIDEN_MIRROR: assert property (
      self_id_receive_enable_reg == $past(link_ctrl_reg[SELF_ID_BIT]))
      else $error("self-id enable output stale");

   AST_SRC_MIRROR: assert property (
      source_address_reg == $past(node_ack_reg[31:16]))
      else $error("source address output stale");

   AST_DECISION_PULSE: assert property (
      pkt_decision_valid == $past(pkt_hdr_valid))
      else $error("decision strobe misplaced");

   AST_NODE_BCAST: assert property (
      pkt_hdr_valid && pkt_dest_node == NODE_BROADCAST &&
      pkt_dest_bus == cfg.bus_identifier
      |=> pkt_accept)
      else $error("broadcast node rejected");

   AST_BUS_BCAST_OWN: assert property (
      pkt_hdr_valid && pkt_dest_bus == BUS_BROADCAST && cfg.node_id_valid &&
      pkt_dest_node == cfg.node_identifier
      |=> pkt_accept)
      else $error("own node on broadcast bus rejected");

   AST_ID_INVALID: assert property (
      pkt_hdr_valid && !cfg.node_id_valid && pkt_dest_node != NODE_BROADCAST
      |=> !pkt_accept)
      else $error("unicast accepted without valid id");

   AST_FOREIGN_NODE: assert property (
      pkt_hdr_valid && pkt_dest_node != NODE_BROADCAST &&
      pkt_dest_node != cfg.node_identifier
      |=> !pkt_accept)
      else $error("foreign node accepted");

   AST_SID_OFF: assert property (
      !cfg.self_id_receive_enable
      |=> !grf_write_valid)
      else $error("self-id forwarded while disabled");

   COV_ACK_UNLOCK_WRITE: cover property (wr_node && diag_register_write_unlock);
   COV_OWN_ACCEPT: cover property (pkt_decision_valid && pkt_accept && node_id_valid_reg);
   COV_SID_PACKET: cover property (grf_write_valid ##1 grf_write_valid);
   COV_TIMEOUT: cover property (at_ack_timeout && !at_ack_valid);
endmodule

/* File: verification/host_bus_model.sv */
`timescale 1ns/1ns
module host_bus_model (
   input  wire logic        clk_sys,
   output logic             host_cs_n,
   output logic [7:0]       host_addr,
   output logic             host_wr,
   output logic [31:0]      host_wdata,
   input  wire logic [31:0] host_rdata_reg
);
   initial begin
      host_cs_n  = 1'b1;
      host_addr  = 8'hff;
      host_wr    = 1'b0;
      host_wdata = 32'h0000_0000;
   end

   // one access, then idle; released lines show the inverse so stale values never match
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
      @(posedge clk_sys);
      #1;
      host_cs_n  = 1'b0;
      host_addr  = a;
      host_wr    = w;
      host_wdata = d;
      @(posedge clk_sys);
      #1;
      host_cs_n  = 1'b1;
      host_addr  = ~a;
      host_wr    = ~w;
      host_wdata = ~d;
      rd         = host_rdata_reg;
   endtask
endmodule

/* File: verification/test_link_node_address_control_regs.sv */
`timescale 1ns/1ns
module test_link_node_address_control_regs;
   import link_regs_pkg::*;
   logic        clk_sys, rst_n, host_cs_n, host_wr, unlock, ack_v, ack_to, hdr_v;
   logic        sid_v, sid_end, dec_v, acc, idv_o, sid_o, grf_v;
   logic [7:0]  host_addr;
   logic [31:0] host_wdata, rdata, sid_q, grf_d, v, w, nack, ctrl;
   logic [3:0]  ack_c;
   logic [9:0]  p_bus;
   logic [5:0]  p_node;
   logic [15:0] src;
   integer      seed, fail_count, checks_done, cycles, i, e;
   logic [31:0] q[$];

   host_bus_model host (.clk_sys(clk_sys), .host_cs_n(host_cs_n), .host_addr(host_addr),
      .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata_reg(rdata));

   link_node_address_control_regs dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .host_cs_n(host_cs_n), .host_addr(host_addr), .host_wr(host_wr),
      .host_wdata(host_wdata), .host_rdata_reg(rdata), .diag_register_write_unlock(unlock),
      .at_ack_valid(ack_v), .at_ack_code(ack_c), .at_ack_timeout(ack_to),
      .pkt_hdr_valid(hdr_v), .pkt_dest_bus(p_bus), .pkt_dest_node(p_node),
      .pkt_decision_valid(dec_v), .pkt_accept(acc), .source_address_reg(src),
      .node_id_valid_reg(idv_o), .self_id_receive_enable_reg(sid_o),
      .sid_quadlet_valid(sid_v), .sid_quadlet(sid_q), .sid_period_end(sid_end),
      .grf_write_valid(grf_v), .grf_write_data(grf_d));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         wrap_up();
      end
   end

   // one pulse on a strobe; waits out its registered answer
   task automatic pulse(input int kind);
      @(posedge clk_sys);
      #1;
      case (kind)
         0: ack_v = 1'b1;
         1: ack_to = 1'b1;
         2: hdr_v = 1'b1;
         3: sid_v = 1'b1;
         default: sid_end = 1'b1;
      endcase
      @(posedge clk_sys);
      #1;
      {ack_v, ack_to, hdr_v, sid_v, sid_end} = 5'h00;
   endtask

   // self-id period: model judges pairs, odd leftover is bad
   task automatic sid_run(input logic en);
      logic good;
      good = (q.size() % 2 == 0);
      for (e = 0; e < q.size(); e++) begin
         sid_q = q[e];
         pulse(3);
         check({31'h0, grf_v}, {31'h0, en});
         if (en) begin
            check(grf_d, q[e]);
         end
         if (e % 2 == 1 && q[e] !== ~q[e-1]) begin
            good = 1'b0;
         end
         sid_q = $random(seed);
      end
      pulse(4);
      check({31'h0, grf_v}, {31'h0, en});
      if (en) begin
         check(grf_d, {24'h0, good ? ACK_SID_GOOD : ACK_SID_BAD, 4'h0});
      end
      q.delete();
   endtask

   initial begin
      seed = 32'hcfd6_cd3f;
      {fail_count, checks_done, cycles} = 0;
      {rst_n, unlock, ack_v, ack_to, hdr_v, sid_v, sid_end} = 7'h00;
      {ack_c, p_bus, p_node, sid_q} = 52'h0;
      repeat (8) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      nack = NODE_ACK_RESET;
      ctrl = LINK_CTRL_RESET;
      check({16'h0, src}, 32'h0000_ffff);
      host.xfer(1'b1, ADDR_CHIP_ID, $random(seed), v);
      host.xfer(1'b0, ADDR_CHIP_ID, 32'h0, v);
      check(v, {CHIP_VERSION, CHIP_REVISION});
      host.xfer(1'b0, ADDR_NODE_ACK, 32'h0, v);
      check(v, nack);
      host.xfer(1'b0, ADDR_LINK_CTRL, 32'h0, v);
      check(v, ctrl);
      host.xfer(1'b1, 8'h0c, 32'hffff_ffff, v);
      host.xfer(1'b0, 8'h0c, 32'h0, v);
      check(v, 32'h0000_0000);
      for (i = 0; i < 8; i++) begin
         w = $random(seed);
         unlock = i[0];
         host.xfer(1'b1, ADDR_NODE_ACK, w, v);
         nack = (w & NODE_ADDR_MASK) | ((unlock ? w : nack) & ACK_FIELD_MASK);
         host.xfer(1'b0, ADDR_NODE_ACK, 32'h0, v);
         check(v, nack);
         check({16'h0, src}, {16'h0, nack[31:16]});
         w = $random(seed);
         host.xfer(1'b1, ADDR_LINK_CTRL, w, v);
         host.xfer(1'b0, ADDR_LINK_CTRL, 32'h0, v);
         check(v, w);
         check({30'h0, idv_o, sid_o}, {30'h0, w[ID_VALID_BIT], w[SELF_ID_BIT]});
      end
      unlock = 1'b0;
      for (i = 0; i < 5; i++) begin
         w = $random(seed);
         ack_c = w[3:0];
         pulse(i == 4 ? 1 : 0);
         nack[7:4] = (i == 4) ? ACK_TIMEOUT_CODE : ack_c;
         host.xfer(1'b0, ADDR_NODE_ACK, 32'h0, v);
         check(v, nack);
      end
      for (i = 0; i < 24; i++) begin
         if (i % 12 == 0) begin
            ctrl = {i == 12, 31'h0};
            host.xfer(1'b1, ADDR_LINK_CTRL, ctrl, v);
         end
         w = $random(seed);
         p_bus = (i % 3 == 0) ? nack[31:22] : (i % 3 == 1) ? BUS_BROADCAST : w[9:0];
         p_node = ((i / 3) % 4 == 0) ? nack[21:16] : ((i / 3) % 4 == 1) ? NODE_BROADCAST
                  : w[15:10];
         pulse(2);
         check({31'h0, dec_v}, 32'h1);
         check({31'h0, acc}, {31'h0, (p_bus == BUS_BROADCAST || p_bus == nack[31:22])
            && (p_node == NODE_BROADCAST || (ctrl[31] && p_node == nack[21:16]))});
      end
      host.xfer(1'b1, ADDR_LINK_CTRL, 32'h4000_0000, v);
      for (i = 0; i < 3; i++) begin
         w = $random(seed);
         q.push_back(w);
         q.push_back(i == 1 ? w ^ 32'h0000_0100 : ~w);
         if (i == 2) begin
            q.push_back(w);
         end
         sid_run(1'b1);
      end
      host.xfer(1'b1, ADDR_LINK_CTRL, 32'h0000_0000, v);
      q.push_back(32'h1234_5678);
      sid_run(1'b0);
      wrap_up();
   end
endmodule
